// ### dlha_checker.sv
// port assertions for the handshake controller
`timescale 1ns/100ps
module dlha_checker
    import dlha_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic debug_wire_pin_in,
    input wire logic debug_wire_pin_out,
    input wire logic debug_wire_pin_oe,
    input wire logic cmd_accept,
    input wire dlha_pkg::dlha_cmd_t cmd_class,
    input wire logic ack_enabled,
    input wire logic ack_pending,
    input wire logic sync_detected,
    input wire logic cmd_aborted
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] lo_r;
    logic [7:0] host_r;
    logic [7:0] acc_r;
    // low cycles driven, host low cycles, cycles since accept
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lo_r <= 8'h00;
            host_r <= 8'h00;
            acc_r <= 8'h00;
        end else begin
            lo_r <= (debug_wire_pin_oe && !debug_wire_pin_out) ? lo_r + 8'h01 : 8'h00;
            host_r <= debug_wire_pin_in ? 8'h00 : (host_r == 8'hFF ? host_r : host_r + 8'h01);
            acc_r <= cmd_accept ? 8'h00 : (acc_r == 8'hFF ? acc_r : acc_r + 8'h01);
        end
    end
    a_reset_ack_off: assert property ($rose(arst_n) |-> !ack_enabled && !ack_pending)
        else $error("handshake on after reset");
    a_enable_pends: assert property (cmd_accept && cmd_class == DLHA_CMD_ACK_ENABLE
        |=> ack_enabled && ack_pending) else $error("enable command not applied");
    a_disable_clears: assert property (cmd_accept && cmd_class == DLHA_CMD_ACK_DISABLE
        |=> !ack_enabled && !ack_pending) else $error("disable command not applied");
    a_off_no_pend: assert property (cmd_accept && !ack_enabled
        && cmd_class != DLHA_CMD_ACK_ENABLE |=> !ack_pending) else $error("pending while off");
    a_on_pends: assert property (cmd_accept && ack_enabled
        && cmd_class != DLHA_CMD_ACK_DISABLE |=> ack_pending) else $error("accept not pending");
    a_pulse_low_len: assert property ($rose(debug_wire_pin_out)
        |-> lo_r == DLHA_ACK_LOW || lo_r == DLHA_SYNC_RESP_LOW) else $error("bad low length");
    a_speedup_one: assert property ($rose(debug_wire_pin_out) |=> !debug_wire_pin_oe)
        else $error("speedup not one tick");
    a_ack_min_gap: assert property ($rose(debug_wire_pin_oe) |-> acc_r >= DLHA_ACK_MIN_DELAY)
        else $error("pulse too soon after command");
    a_sync_long_low: assert property (sync_detected |-> host_r >= DLHA_SYNC_MIN_LOW)
        else $error("sync on short low");
    a_abort_clears: assert property (cmd_aborted |-> !ack_pending)
        else $error("pending kept after abort");
    c_sync: cover property (sync_detected);
    c_abort: cover property (cmd_aborted && !sync_detected);
    c_pulse: cover property ($rose(debug_wire_pin_oe));
endmodule : dlha_checker

bind dlha_ctrl dlha_checker u_dlha_checker (.core_clk, .arst_n, .debug_wire_pin_in,
    .debug_wire_pin_out, .debug_wire_pin_oe, .cmd_accept, .cmd_class, .ack_enabled,
    .ack_pending, .sync_detected, .cmd_aborted);

// ### dlha_ctrl.sv
// handshake pulse control, timing-reference detection and abort for the debug wire
`timescale 1ns/100ps
// Summary of operation
// - long low pulse runs timing-reference reply and aborts pending command and pulse.
// - firmware access in flight still completes, but its handshake pulse is dropped.
// - resume, resume-until-halt and single-step are not cancelled; only pulse dropped.
// - short low pulse is no timing request; pending pulse aborted at falling edge.
// - after any abort, next falling edge starts a new command.
// - no guard against speedup pulse clashing with host timing request.
// - handshake-enable command switches pulses on; handshake-disable switches off.
// - handshake-enable command is itself answered with a pulse.
// - handshake disabled after reset.
// - read pulse once bus cycle finished and data ready.
// - write pulse after data received and bus cycle completed.
// - halt command pulses when cpu enters background mode; abortable.
// - resume command pulses when cpu leaves background mode; abortable.
// - resume-until-halt pulses on next background entry; abortable.
// - single-step pulses on background re-entry after one instruction; abortable.
// - no timeout while waiting to issue a pulse; host aborts instead.
// - handshake pulse is 16 ticks low then a brief high speedup.
// - pulse no sooner than 32 ticks after command end.
// - timing reply is 128 ticks low then one-tick speedup.
module dlha_ctrl (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic serial_tick,
    input wire logic debug_wire_pin_in,
    output logic debug_wire_pin_out,
    output logic debug_wire_pin_oe,
    input wire logic cmd_accept,
    input wire dlha_pkg::dlha_cmd_t cmd_class,
    input wire logic bus_cycle_done,
    input wire logic cpu_debug_halt_instruction_enter,
    input wire logic cpu_debug_halt_instruction_exit,
    output logic ack_enabled,
    output logic ack_pending,
    output logic sync_detected,
    output logic cmd_aborted,
    output logic new_cmd_edge
);
    import dlha_pkg::*;

    dlha_main_t s_r;
    dlha_main_t s_nxt;
    dlha_pulse_if pif ();

    logic fall;
    logic host_low;
    logic ready_evt;

    // completion event that matches the pending command class
    function automatic logic class_done(input dlha_cmd_t c, input logic bus_done,
                                        input logic bg_in, input logic bg_out);
        case (c)
            DLHA_CMD_READ: class_done = bus_done;
            DLHA_CMD_WRITE: class_done = bus_done;
            DLHA_CMD_HALT: class_done = bg_in;
            DLHA_CMD_RESUME: class_done = bg_out;
            DLHA_CMD_RESUME_UNTIL: class_done = bg_in;
            DLHA_CMD_STEP: class_done = bg_in;
            default: class_done = 1'b0;
        endcase
    endfunction : class_done

    assign pif.clk_en = clk_en;
    assign pif.serial_tick = serial_tick;
    assign pif.start = s_r.gen_start;
    assign pif.low_len = s_r.gen_len;

    dlha_pulse_gen u_gen (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pif(pif)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.gen_start = 1'b0;
        s_nxt.sync_pulse = 1'b0;
        s_nxt.abort_pulse = 1'b0;
        s_nxt.new_cmd_pulse = 1'b0;

        // two-stage pin synchroniser
        s_nxt.pin_s1 = debug_wire_pin_in;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_q = s_r.pin_s2;

        // our own drive is not host activity
        host_low = !s_r.pin_s2 && !s_r.pin_oe && !pif.busy && !s_r.gen_start;
        fall = s_r.pin_q && !s_r.pin_s2 && !s_r.pin_oe && !pif.busy;

        // low time of the host pulse, saturating at the request threshold
        if (s_r.pin_s2) begin
            s_nxt.low_cnt = 8'h00;
        end else if (host_low && serial_tick && s_r.low_cnt != DLHA_SYNC_MIN_LOW) begin
            s_nxt.low_cnt = s_r.low_cnt + 8'h01;
        end

        // spacing from command end; no upper bound on the wait
        if (serial_tick && s_r.min_cnt != DLHA_ACK_MIN_DELAY) begin
            s_nxt.min_cnt = s_r.min_cnt + 6'h01;
        end

        ready_evt = class_done(s_r.pend_cmd, bus_cycle_done, cpu_debug_halt_instruction_enter, cpu_debug_halt_instruction_exit);
        if (s_r.pending && ready_evt) begin
            s_nxt.ready = 1'b1;
        end

        // command acceptance
        if (cmd_accept) begin
            s_nxt.min_cnt = 6'h00;
            if (cmd_class == DLHA_CMD_ACK_ENABLE) begin
                s_nxt.ack_en = 1'b1;
                s_nxt.pending = 1'b1;
                s_nxt.ready = 1'b1;
                s_nxt.pend_cmd = cmd_class;
            end else if (cmd_class == DLHA_CMD_ACK_DISABLE) begin
                s_nxt.ack_en = 1'b0;
                s_nxt.pending = 1'b0;
                s_nxt.ready = 1'b0;
            end else if (s_r.ack_en) begin
                s_nxt.pending = 1'b1;
                s_nxt.ready = 1'b0;
                s_nxt.pend_cmd = cmd_class;
            end
        end

        // first falling edge after an abort opens a new command
        if (fall && s_r.after_abort && s_r.state == DLHA_ST_IDLE) begin
            s_nxt.new_cmd_pulse = 1'b1;
            s_nxt.after_abort = 1'b0;
        end

        // short abort: edge perceived while a pulse is owed
        // a command ending in the same cycle wins over the edge
        if (fall && s_r.pending && !cmd_accept && s_r.state == DLHA_ST_IDLE) begin
            s_nxt.pending = 1'b0;
            s_nxt.ready = 1'b0;
            s_nxt.abort_pulse = 1'b1;
            s_nxt.after_abort = 1'b1;
        end

        case (s_r.state)
            DLHA_ST_IDLE: begin
                if (host_low && serial_tick && s_r.low_cnt == DLHA_SYNC_MIN_LOW - 8'h01) begin
                    // only the owed pulse is dropped; bus access and cpu run go on
                    s_nxt.state = DLHA_ST_WAIT_HIGH;
                    s_nxt.sync_pulse = 1'b1;
                    // a command ending in the same cycle keeps its pending flag
                    if (!cmd_accept) begin
                        s_nxt.pending = 1'b0;
                        s_nxt.ready = 1'b0;
                        s_nxt.abort_pulse = s_r.pending;
                    end
                end else if (s_r.pending && s_r.ready && !cmd_accept
                             && s_r.min_cnt == DLHA_ACK_MIN_DELAY
                             && s_r.pin_s2 && !(fall && s_r.pending)) begin
                    // a host request landing now is not guarded against
                    s_nxt.state = DLHA_ST_ACK;
                    s_nxt.gen_start = 1'b1;
                    s_nxt.gen_len = DLHA_ACK_LOW;
                    s_nxt.pending = 1'b0;
                    s_nxt.ready = 1'b0;
                end
            end
            DLHA_ST_WAIT_HIGH: begin
                if (s_r.pin_s2) begin
                    s_nxt.state = DLHA_ST_SYNC_DELAY;
                    s_nxt.delay_cnt = 5'h00;
                end
            end
            DLHA_ST_SYNC_DELAY: begin
                if (serial_tick) begin
                    if (s_r.delay_cnt == DLHA_SYNC_DELAY - 5'h01) begin
                        s_nxt.state = DLHA_ST_SYNC_RESP;
                        s_nxt.gen_start = 1'b1;
                        s_nxt.gen_len = DLHA_SYNC_RESP_LOW;
                    end else begin
                        s_nxt.delay_cnt = s_r.delay_cnt + 5'h01;
                    end
                end
            end
            DLHA_ST_SYNC_RESP: begin
                if (!s_r.gen_start && !pif.busy) begin
                    s_nxt.state = DLHA_ST_IDLE;
                    s_nxt.after_abort = 1'b1;
                end
            end
            DLHA_ST_ACK: begin
                if (!s_r.gen_start && !pif.busy) begin
                    s_nxt.state = DLHA_ST_IDLE;
                end
            end
            default: begin
                s_nxt.state = DLHA_ST_IDLE;
            end
        endcase

        // speedup is driven high, low phase driven low, else released
        s_nxt.pin_oe = pif.drive_low || pif.drive_high;
        s_nxt.pin_out = pif.drive_high;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= DLHA_MAIN_RST;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign debug_wire_pin_out = s_r.pin_out;
    assign debug_wire_pin_oe = s_r.pin_oe;
    assign ack_enabled = s_r.ack_en;
    assign ack_pending = s_r.pending;
    assign sync_detected = s_r.sync_pulse;
    assign cmd_aborted = s_r.abort_pulse;
    assign new_cmd_edge = s_r.new_cmd_pulse;

endmodule : dlha_ctrl

// ### dlha_pkg.sv
// constants, types and reset values for the debug link handshake and abort block
package dlha_pkg;

    // serial clock tick counts
    localparam logic [7:0] DLHA_SYNC_MIN_LOW = 8'h80;
    localparam logic [7:0] DLHA_SYNC_RESP_LOW = 8'h80;
    localparam logic [7:0] DLHA_ACK_LOW = 8'h10;
    localparam logic [5:0] DLHA_ACK_MIN_DELAY = 6'h20;
    localparam logic [4:0] DLHA_SYNC_DELAY = 5'h10;
    localparam logic [7:0] DLHA_SHORT_ABORT_MIN = 8'h04;

    // command classes reported by the command decoder
    typedef enum logic [2:0] {
        DLHA_CMD_READ = 3'h0,
        DLHA_CMD_WRITE = 3'h1,
        DLHA_CMD_HALT = 3'h2,
        DLHA_CMD_RESUME = 3'h3,
        DLHA_CMD_RESUME_UNTIL = 3'h4,
        DLHA_CMD_STEP = 3'h5,
        DLHA_CMD_ACK_ENABLE = 3'h6,
        DLHA_CMD_ACK_DISABLE = 3'h7
    } dlha_cmd_t;

    typedef enum logic [4:0] {
        DLHA_ST_IDLE = 5'h01,
        DLHA_ST_WAIT_HIGH = 5'h02,
        DLHA_ST_SYNC_DELAY = 5'h04,
        DLHA_ST_SYNC_RESP = 5'h08,
        DLHA_ST_ACK = 5'h10
    } dlha_state_t;

    typedef enum logic [2:0] {
        DLHA_G_IDLE = 3'h1,
        DLHA_G_LOW = 3'h2,
        DLHA_G_HIGH = 3'h4
    } dlha_gen_state_t;

    typedef struct packed {
        dlha_state_t state;
        logic pin_s1;
        logic pin_s2;
        logic pin_q;
        logic [7:0] low_cnt;
        logic [4:0] delay_cnt;
        logic [5:0] min_cnt;
        logic ack_en;
        logic pending;
        logic ready;
        dlha_cmd_t pend_cmd;
        logic after_abort;
        logic gen_start;
        logic [7:0] gen_len;
        logic pin_out;
        logic pin_oe;
        logic sync_pulse;
        logic abort_pulse;
        logic new_cmd_pulse;
    } dlha_main_t;

    typedef struct packed {
        dlha_gen_state_t state;
        logic [7:0] cnt;
    } dlha_gen_t;

    localparam dlha_main_t DLHA_MAIN_RST = '{
        state: DLHA_ST_IDLE,
        pin_s1: 1'b1,
        pin_s2: 1'b1,
        pin_q: 1'b1,
        low_cnt: 8'h00,
        delay_cnt: 5'h00,
        min_cnt: 6'h00,
        ack_en: 1'b0,
        pending: 1'b0,
        ready: 1'b0,
        pend_cmd: DLHA_CMD_READ,
        after_abort: 1'b0,
        gen_start: 1'b0,
        gen_len: 8'h00,
        pin_out: 1'b0,
        pin_oe: 1'b0,
        sync_pulse: 1'b0,
        abort_pulse: 1'b0,
        new_cmd_pulse: 1'b0
    };

    localparam dlha_gen_t DLHA_GEN_RST = '{state: DLHA_G_IDLE, cnt: 8'h00};

endpackage : dlha_pkg

// ### dlha_probe.sv
// debug probe model: host low pulse then one-tick speedup
`timescale 1ns/100ps
module dlha_probe (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [7:0] low_len,
    output logic pin_oe,
    output logic pin_out,
    output logic busy
);
    logic [7:0] cnt_r;
    assign busy = pin_oe;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 8'h00;
            pin_oe <= 1'h0;
            pin_out <= 1'h0;
        end else if (go && !busy) begin
            cnt_r <= low_len;
            pin_oe <= 1'h1;
            pin_out <= 1'h0;
        end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
        end else if (cnt_r == 8'h01) begin
            cnt_r <= 8'h00;
            pin_out <= 1'h1;
        end else begin
            pin_oe <= 1'h0;
            pin_out <= 1'h0;
        end
    end
endmodule : dlha_probe

// ### dlha_pulse_gen.sv
// low pulse of a given tick count followed by a one-tick speedup pulse
`timescale 1ns/100ps
module dlha_pulse_gen (
    input wire logic core_clk,
    input wire logic arst_n,
    dlha_pulse_if.gen pif
);
    import dlha_pkg::*;

    dlha_gen_t s_r;
    dlha_gen_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            DLHA_G_IDLE: begin
                if (pif.start) begin
                    s_nxt.state = DLHA_G_LOW;
                    s_nxt.cnt = 8'h00;
                end
            end
            DLHA_G_LOW: begin
                if (pif.serial_tick) begin
                    if (s_r.cnt == pif.low_len - 8'h01) begin
                        s_nxt.state = DLHA_G_HIGH;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 8'h01;
                    end
                end
            end
            DLHA_G_HIGH: begin
                if (pif.serial_tick) begin
                    s_nxt.state = DLHA_G_IDLE;
                end
            end
            default: begin
                s_nxt = DLHA_GEN_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= DLHA_GEN_RST;
        end else if (pif.clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign pif.busy = (s_r.state != DLHA_G_IDLE);
    assign pif.drive_low = (s_r.state == DLHA_G_LOW);
    assign pif.drive_high = (s_r.state == DLHA_G_HIGH);

endmodule : dlha_pulse_gen

// ### dlha_pulse_if.sv
// link between the handshake controller and the pin pulse generator
`timescale 1ns/100ps
interface dlha_pulse_if;
    logic clk_en;
    logic serial_tick;
    logic start;
    logic [7:0] low_len;
    logic busy;
    logic drive_low;
    logic drive_high;

    modport ctrl (output clk_en, output serial_tick, output start, output low_len,
                  input busy, input drive_low, input drive_high);
    modport gen (input clk_en, input serial_tick, input start, input low_len,
                 output busy, output drive_low, output drive_high);
endinterface : dlha_pulse_if

// ### testbench.sv
// self-checking bench for the handshake controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import dlha_pkg::*;
    logic core_clk, arst_n, acc, go, oe, out, p_oe, p_out, sync, abrt, nce, en, pend;
    logic run, tick;
    logic [2:0] ev;
    logic [7:0] plen;
    dlha_cmd_t cls;
    wire pin = oe ? out : (p_oe ? p_out : 1'h1);
    int fails = 0;
    int n_checks = 0;
    int ns = 0;
    int na = 0;
    int nn = 0;
    dlha_ctrl u_dlha_ctrl (.core_clk(core_clk), .arst_n(arst_n), .clk_en(run),
        .serial_tick(tick), .debug_wire_pin_in(pin), .debug_wire_pin_out(out),
        .debug_wire_pin_oe(oe), .cmd_accept(acc), .cmd_class(cls), .bus_cycle_done(ev[0]),
        .cpu_debug_halt_instruction_enter(ev[1]), .cpu_debug_halt_instruction_exit(ev[2]), .ack_enabled(en), .ack_pending(pend),
        .sync_detected(sync), .cmd_aborted(abrt), .new_cmd_edge(nce));
    dlha_probe u_dlha_probe (.core_clk(core_clk), .arst_n(arst_n), .go(go), .low_len(plen),
        .pin_oe(p_oe), .pin_out(p_out), .busy());
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        ns += sync;
        na += abrt;
        nn += nce;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic cmd(input dlha_cmd_t c);
        cls = c;
        acc = 1'h1;
        cyc(1);
        acc = 1'h0;
    endtask : cmd
    task automatic fire(input logic [2:0] m);
        ev = m;
        cyc(1);
        ev = 3'h0;
    endtask : fire
    task automatic host(input logic [7:0] l);
        plen = l;
        go = 1'h1;
        cyc(1);
        go = 1'h0;
        cyc(int'(l) + 2);
    endtask : host
    task automatic quiet(input int n, output logic d);
        d = 1'h0;
        repeat (n) begin
            cyc(1);
            d |= oe;
        end
    endtask : quiet
    task automatic grab(output int lo, output int wt, output logic e);
        lo = 0;
        wt = 0;
        while (oe !== 1'h1 && wt < 2000) begin
            cyc(1);
            wt++;
        end
        while (oe === 1'h1 && out === 1'h0 && lo < 300) begin
            cyc(1);
            lo++;
        end
        cyc(1);
        e = oe;
    endtask : grab
    task automatic t_reset;
        logic d;
        `CHK("en", 1'h0, en)
        cmd(DLHA_CMD_READ);
        fire(3'h1);
        quiet(60, d);
        `CHK("no_ack_off", 1'h0, d)
        $display("test reset done");
    endtask : t_reset
    task automatic t_enable;
        int lo, wt;
        logic e;
        cmd(DLHA_CMD_ACK_ENABLE);
        `CHK("en", 1'h1, en)
        `CHK("pend", 1'h1, pend)
        grab(lo, wt, e);
        `CHK("ack_len", DLHA_ACK_LOW, lo)
        `CHK("ack_gap", 1'h1, wt + 1 >= DLHA_ACK_MIN_DELAY)
        `CHK("released", 1'h0, e)
        `CHK("pend_clr", 1'h0, pend)
        $display("test enable done");
    endtask : t_enable
    task automatic t_classes;
        dlha_cmd_t c[6] = '{DLHA_CMD_READ, DLHA_CMD_WRITE, DLHA_CMD_HALT,
            DLHA_CMD_RESUME, DLHA_CMD_RESUME_UNTIL, DLHA_CMD_STEP};
        logic [2:0] m[6] = '{3'h1, 3'h1, 3'h2, 3'h4, 3'h2, 3'h2};
        int lo, wt;
        logic d, e;
        foreach (c[i]) begin
            cmd(c[i]);
            fire(3'h7 ^ m[i]);
            quiet(40, d);
            `CHK("early_ack", 1'h0, d)
            fire(m[i]);
            grab(lo, wt, e);
            `CHK("ack_len", DLHA_ACK_LOW, lo)
        end
        $display("test classes done");
    endtask : t_classes
    task automatic t_disable;
        logic d;
        cmd(DLHA_CMD_ACK_DISABLE);
        `CHK("en", 1'h0, en)
        cyc(1);
        cmd(DLHA_CMD_WRITE);
        `CHK("pend", 1'h0, pend)
        fire(3'h1);
        quiet(60, d);
        `CHK("no_ack", 1'h0, d)
        $display("test disable done");
    endtask : t_disable
    task automatic t_sync;
        int lo, wt;
        logic d, e;
        cmd(DLHA_CMD_ACK_ENABLE);
        grab(lo, wt, e);
        cmd(DLHA_CMD_READ);
        ns = 0;
        na = 0;
        host(8'h84);
        `CHK("sync", 1, ns)
        `CHK("abort", 1, na)
        `CHK("pend", 1'h0, pend)
        grab(lo, wt, e);
        `CHK("sync_len", DLHA_SYNC_RESP_LOW, lo)
        fire(3'h1);
        quiet(60, d);
        `CHK("late_ack", 1'h0, d)
        nn = 0;
        host(8'h04);
        `CHK("new_cmd", 1, nn)
        $display("test sync abort done");
    endtask : t_sync
    task automatic t_short;
        logic d;
        cmd(DLHA_CMD_STEP);
        na = 0;
        ns = 0;
        host(8'h06);
        `CHK("abort", 1, na)
        `CHK("sync", 0, ns)
        fire(3'h2);
        quiet(60, d);
        `CHK("step_ack", 1'h0, d)
        nn = 0;
        host(8'h06);
        `CHK("new_cmd", 1, nn)
        $display("test short abort done");
    endtask : t_short
    task automatic t_freeze;
        int lo, wt;
        logic d, e;
        cmd(DLHA_CMD_READ);
        tick = 1'h0;
        fire(3'h1);
        quiet(50, d);
        `CHK("tick_hold", 1'h0, d)
        tick = 1'h1;
        run = 1'h0;
        quiet(50, d);
        `CHK("freeze_hold", 1'h0, d)
        `CHK("freeze_pend", 1'h1, pend)
        run = 1'h1;
        grab(lo, wt, e);
        `CHK("freeze_ack", DLHA_ACK_LOW, lo)
        `CHK("freeze_gap", 1'h1, wt >= DLHA_ACK_MIN_DELAY)
        `CHK("freeze_rel", 1'h0, e)
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_midreset;
        logic d;
        cmd(DLHA_CMD_ACK_ENABLE);
        `CHK("en_set", 1'h1, en)
        arst_n = 1'h0;
        cyc(2);
        arst_n = 1'h1;
        cyc(2);
        `CHK("en_rst", 1'h0, en)
        `CHK("pend_rst", 1'h0, pend)
        quiet(60, d);
        `CHK("no_ack_rst", 1'h0, d)
        $display("test mid reset done");
    endtask : t_midreset
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #2000000;
        fails++;
        $display("watchdog expired");
        summarize();
    end
    initial begin
        arst_n = 1'h0;
        acc = 1'h0;
        go = 1'h0;
        ev = 3'h0;
        plen = 8'h00;
        cls = DLHA_CMD_READ;
        run = 1'h1;
        tick = 1'h1;
        cyc(20);
        arst_n = 1'h1;
        cyc(2);
        t_reset();
        t_enable();
        t_classes();
        t_disable();
        t_sync();
        t_freeze();
        t_short();
        t_midreset();
        summarize();
    end
endmodule : testbench
